// >>> design/rstack_pkg.sv
// package for the hardware return stack: register offsets, field layout, reset values, types
// assumes a single 125 MHz clock domain and a synchronous active-high reset
package rstack_pkg;

  localparam int unsigned DEPTH = 16;
  localparam int unsigned ENTRY_W = 15;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_PTR = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_TOP_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TOP_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h5;

  // field positions
  localparam int unsigned BIT_OVF = 0;
  localparam int unsigned BIT_UNF = 1;
  localparam int unsigned BIT_FAULT_EN = 0;
  localparam int unsigned HIGH_W = 7;

  // reset values
  localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h1f;
  localparam logic [PTR_W-1:0] PTR_LAST = 5'h0f;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic FAULT_EN_RST = 1'b0;
  localparam int unsigned FAULT_PULSE_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_PUSH = 3'b010,
    OP_POP = 3'b100
  } op_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [ENTRY_W-1:0] pc;
  } core_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : rstack_pkg

// >>> design/rstack_mem.sv
// sixteen-entry storage of the return stack, one write port and one registered read port
// assumes one writer per cycle; read data lag the read index by one clock
`timescale 1ns/10ps
`default_nettype none
module rstack_mem (
  // clock
  input wire logic sys_clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [rstack_pkg::IDX_W-1:0] wr_idx_i,
  input wire logic [rstack_pkg::ENTRY_W-1:0] wr_data_i,
  // read port
  input wire logic [rstack_pkg::IDX_W-1:0] rd_idx_i,
  output logic [rstack_pkg::ENTRY_W-1:0] rd_data_o
);
  import rstack_pkg::*;

  // contents are not reset, as in the real stack they are undefined after reset
  logic [ENTRY_W-1:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_idx_i];
  end

endmodule : rstack_mem
`default_nettype wire

// >>> design/hw_return_stack.sv
// hardware return-address stack for an 8-bit core, with pointer, top-entry window and fault flags
// assumes the core raises at most one of push and pop per cycle and holds pc valid beside push
// Functional notes
// - sixteen 15-bit entries, outside program/data space
// - calls and interrupt vectoring push the pc
// - all three return kinds pop into pc
// - push and pop leave pc high latch alone
// - fault reset off: stack wraps circularly
// - overflow and underflow flags always set
// - top entry registers follow the stack pointer
// - five-bit pointer, software readable and writable
// - push increments then writes; pop reads then decrements
// - 0x1f means empty; one push gives 0x00
// - fault reset on: overflow/underflow requests device reset
// - pointer resets to empty 0x1f
`timescale 1ns/10ps
`default_nettype none
module hw_return_stack (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // core side
  input wire rstack_pkg::core_req_t core_req_i,
  output logic [rstack_pkg::ENTRY_W-1:0] pop_pc_o,
  output logic pop_valid_o,
  // register port
  input wire rstack_pkg::reg_req_t reg_req_i,
  output logic [rstack_pkg::DATA_W-1:0] reg_rdata_o,
  // system
  output logic device_reset_req_o,
  output logic irq_o
);
  import rstack_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [1:0] flags;
    logic [1:0] mask;
    logic fault_en;
    logic [DATA_W-1:0] rdata;
    logic rd_top_low;
    logic rd_top_high;
    logic pop_valid;
    logic reset_req;
    logic fwd;
    logic [ENTRY_W-1:0] fwd_data;
    logic [ENTRY_W-1:0] pop_pc;
  } state_t;

  state_t s_q;
  state_t s_d;

  op_t op;
  logic ovf_evt;
  logic unf_evt;
  logic mem_wr;
  logic [IDX_W-1:0] mem_wr_idx;
  logic [ENTRY_W-1:0] mem_wr_data;
  logic [IDX_W-1:0] mem_rd_idx;
  logic [ENTRY_W-1:0] mem_rd_data;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [ENTRY_W-1:0] top_entry;
  logic [DATA_W-1:0] rdata_mux;
  logic [1:0] flag_evt;
  logic [1:0] flags_nxt;
  logic wr_ptr;
  logic wr_top_low;
  logic wr_top_high;
  logic wr_status;
  logic wr_mask;
  logic wr_config;

  // low four bits of the pointer select an entry; the fifth only marks empty/overflow
  function automatic logic [IDX_W-1:0] slot_of(input logic [PTR_W-1:0] p);
    slot_of = p[IDX_W-1:0];
  endfunction : slot_of

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = (r.addr == ofs);
  endfunction : hit

  // one decode per writable register keeps the write paths below short
  assign wr_ptr = reg_req_i.wr && hit(reg_req_i, OFS_PTR);
  assign wr_top_low = reg_req_i.wr && hit(reg_req_i, OFS_TOP_LOW);
  assign wr_top_high = reg_req_i.wr && hit(reg_req_i, OFS_TOP_HIGH);
  assign wr_status = reg_req_i.wr && hit(reg_req_i, OFS_STATUS);
  assign wr_mask = reg_req_i.wr && hit(reg_req_i, OFS_MASK);
  assign wr_config = reg_req_i.wr && hit(reg_req_i, OFS_CONFIG);

  always_comb
  begin
    if (core_req_i.push)
    begin
      op = OP_PUSH;
    end
    else if (core_req_i.pop)
    begin
      op = OP_POP;
    end
    else
    begin
      op = OP_IDLE;
    end
  end

  assign ptr_inc = s_q.ptr + 5'h01;
  assign ptr_dec = s_q.ptr - 5'h01;

  assign ovf_evt = (op == OP_PUSH) && (s_q.ptr == PTR_LAST);
  assign unf_evt = (op == OP_POP) && (s_q.ptr == PTR_EMPTY);
  assign flag_evt[BIT_OVF] = ovf_evt;
  assign flag_evt[BIT_UNF] = unf_evt;

  // each status bit is sticky: its event sets it, a written one clears it, and the set wins
  for (genvar b = 0; b < 2; b++)
  begin : g_flag
    logic nxt;
    always_comb
    begin
      nxt = s_q.flags[b];
      if (wr_status && reg_req_i.wdata[b])
      begin
        nxt = 1'b0;
      end
      if (flag_evt[b])
      begin
        nxt = 1'b1;
      end
    end
    assign flags_nxt[b] = nxt;
  end

  // the storage register misses a write to the very slot it reads, so that word is forwarded for a cycle
  assign top_entry = s_q.fwd ? s_q.fwd_data : mem_rd_data;

  // storage port: push writes the incremented slot; software may write the current top
  always_comb
  begin
    mem_wr = 1'b0;
    mem_wr_idx = slot_of(s_q.ptr);
    mem_wr_data = top_entry;
    case (op)
      OP_PUSH:
      begin
        mem_wr = 1'b1;
        mem_wr_idx = slot_of(ptr_inc);
        mem_wr_data = core_req_i.pc;
      end
      OP_POP, OP_IDLE:
      begin
        // top entry write is read-modify-write of the entry's registered copy
        if (wr_top_low)
        begin
          mem_wr = 1'b1;
          mem_wr_data = {top_entry[ENTRY_W-1:DATA_W], reg_req_i.wdata};
        end
        else if (wr_top_high)
        begin
          mem_wr = 1'b1;
          mem_wr_data = {reg_req_i.wdata[HIGH_W-1:0], top_entry[DATA_W-1:0]};
        end
      end
      default:
      begin
        mem_wr = 1'b0;
      end
    endcase
  end

  // the read index follows the next pointer so the top entry is ready one cycle later
  assign mem_rd_idx = slot_of(s_d.ptr);

  always_comb
  begin
    s_d = s_q;
    s_d.rd_top_low = 1'b0;
    s_d.rd_top_high = 1'b0;
    s_d.pop_valid = 1'b0;
    s_d.reset_req = 1'b0;
    s_d.rdata = '0;
    case (op)
      OP_PUSH:
      begin
        s_d.ptr = ptr_inc;
      end
      OP_POP:
      begin
        s_d.pop_valid = 1'b1;
        s_d.pop_pc = top_entry;
        s_d.ptr = ptr_dec;
      end
      OP_IDLE:
      begin
        // pointer writes lose to push and pop; software should not move it while calls run
        if (wr_ptr)
        begin
          s_d.ptr = reg_req_i.wdata[PTR_W-1:0];
        end
      end
      default:
      begin
        s_d.ptr = s_q.ptr;
      end
    endcase
    s_d.flags = flags_nxt;
    if (wr_mask)
    begin
      s_d.mask = reg_req_i.wdata[1:0];
    end
    if (wr_config)
    begin
      s_d.fault_en = reg_req_i.wdata[BIT_FAULT_EN];
    end
    // remember a write to the slot that the storage register reads next
    s_d.fwd = mem_wr && (mem_wr_idx == slot_of(s_d.ptr));
    s_d.fwd_data = mem_wr_data;
    s_d.reset_req = s_q.fault_en && (ovf_evt || unf_evt);
    if (reg_req_i.rd)
    begin
      if (hit(reg_req_i, OFS_PTR))
      begin
        s_d.rdata = {{(DATA_W-PTR_W){1'b0}}, s_q.ptr};
      end
      else if (hit(reg_req_i, OFS_TOP_LOW))
      begin
        s_d.rd_top_low = 1'b1;
      end
      else if (hit(reg_req_i, OFS_TOP_HIGH))
      begin
        s_d.rd_top_high = 1'b1;
      end
      else if (hit(reg_req_i, OFS_STATUS))
      begin
        s_d.rdata = {6'h00, s_q.flags};
      end
      else if (hit(reg_req_i, OFS_MASK))
      begin
        s_d.rdata = {6'h00, s_q.mask};
      end
      else if (hit(reg_req_i, OFS_CONFIG))
      begin
        s_d.rdata = {7'h00, s_q.fault_en};
      end
    end
    // fault reset restores the empty pointer and clears the flags too, so software cannot see the cause
    if (srst_i)
    begin
      s_d.ptr = PTR_EMPTY;
      s_d.flags = FLAGS_RST;
      s_d.mask = MASK_RST;
      s_d.fault_en = FAULT_EN_RST;
      s_d.pop_valid = 1'b0;
      s_d.reset_req = 1'b0;
      s_d.rd_top_low = 1'b0;
      s_d.rd_top_high = 1'b0;
      s_d.rdata = '0;
      s_d.fwd = 1'b0;
      s_d.pop_pc = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    s_q <= s_d;
  end

  // pop data is taken from the entry before the pointer moves
  rstack_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(mem_wr),
    .wr_idx_i(mem_wr_idx),
    .wr_data_i(mem_wr_data),
    .rd_idx_i(mem_rd_idx),
    .rd_data_o(mem_rd_data)
  );

  // top entry bytes bypass the state copy so a read right after a push sees the new word
  always_comb
  begin
    rdata_mux = s_q.rdata;
    if (s_q.rd_top_low)
    begin
      rdata_mux = top_entry[DATA_W-1:0];
    end
    else if (s_q.rd_top_high)
    begin
      rdata_mux = {1'b0, top_entry[ENTRY_W-1:DATA_W]};
    end
  end

  // the pc high latch lives outside this block, so no stack operation can reach it
  assign pop_pc_o = s_q.pop_pc;
  assign pop_valid_o = s_q.pop_valid;
  assign reg_rdata_o = rdata_mux;
  // only a pulse: the system must turn it into a full device reset
  assign device_reset_req_o = s_q.reset_req;
  assign irq_o = |(s_q.flags & s_q.mask);

endmodule : hw_return_stack
`default_nettype wire

// >>> dv/rstack_core_model.sv
// core-side model: issues pushes and pops as calls and returns do
// assumes one task at a time, started from the bench
`timescale 1ns/10ps
`default_nettype none
module rstack_core_model
  import rstack_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // request and answer
  output var rstack_pkg::core_req_t core_req_o,
  input wire logic [rstack_pkg::ENTRY_W-1:0] pop_pc_i,
  input wire logic pop_valid_i
);
  logic [ENTRY_W-1:0] ret_pc;
  logic ret_seen;
  initial core_req_o = '0;
  // pc is inverted once released so a stale value cannot pass
  task automatic call(input logic [ENTRY_W-1:0] pc);
    @(posedge sys_clk_i) core_req_o <= '{push: 1'b1, pop: 1'b0, pc: pc};
    @(posedge sys_clk_i) core_req_o <= '{push: 1'b0, pop: 1'b0, pc: ~pc};
  endtask : call
  task automatic ret();
    @(posedge sys_clk_i) core_req_o.pop <= 1'b1;
    @(posedge sys_clk_i) core_req_o.pop <= 1'b0;
    @(negedge sys_clk_i) ret_pc = pop_pc_i;
    ret_seen = pop_valid_i;
  endtask : ret
  // push and pop on consecutive edges: the pop must return the word just pushed
  task automatic call_ret(input logic [ENTRY_W-1:0] pc);
    @(posedge sys_clk_i) core_req_o <= '{push: 1'b1, pop: 1'b0, pc: pc};
    @(posedge sys_clk_i) core_req_o <= '{push: 1'b0, pop: 1'b1, pc: ~pc};
    @(posedge sys_clk_i) core_req_o.pop <= 1'b0;
    @(negedge sys_clk_i) ret_pc = pop_pc_i;
    ret_seen = pop_valid_i;
  endtask : call_ret
endmodule : rstack_core_model
`default_nettype wire

// >>> dv/hw_return_stack_props.sv
// port assertions for the return stack
// assumes a bind onto every hw_return_stack
`timescale 1ns/10ps
`default_nettype none
module hw_return_stack_props
  import rstack_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // watched ports
  input wire rstack_pkg::core_req_t core_req_i,
  input wire logic [rstack_pkg::ENTRY_W-1:0] pop_pc_o,
  input wire logic pop_valid_o,
  input wire rstack_pkg::reg_req_t reg_req_i,
  input wire logic [rstack_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic device_reset_req_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  sequence pop_s;
    core_req_i.pop && !core_req_i.push;
  endsequence
  sequence rd_s(a);
    reg_req_i.rd && reg_req_i.addr == a;
  endsequence
  pop_answer_a: assert property (pop_s |=> pop_valid_o) else $error("pop not answered");
  no_pop_a: assert property (!core_req_i.pop |=> !pop_valid_o) else $error("stray pop valid");
  idle_read_a: assert property (!reg_req_i.rd |=> reg_rdata_o == '0) else $error("idle data");
  ptr_field_a: assert property (rd_s(OFS_PTR) |=> reg_rdata_o[7:5] == 3'h0) else $error("ptr width");
  high_top_a: assert property (rd_s(OFS_TOP_HIGH) |=> !reg_rdata_o[7]) else $error("high bit7");
  unmapped_read_a: assert property (reg_req_i.rd && reg_req_i.addr > OFS_CONFIG |=> reg_rdata_o == '0)
    else $error("unmapped data");
  fault_pulse_a: assert property (device_reset_req_o |=> !device_reset_req_o) else $error("long reset");
  fault_cause_a: assert property (device_reset_req_o |-> $past(core_req_i.push || core_req_i.pop))
    else $error("reset without op");
endmodule : hw_return_stack_props
bind hw_return_stack hw_return_stack_props props (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .core_req_i(core_req_i), .pop_pc_o(pop_pc_o), .pop_valid_o(pop_valid_o), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .device_reset_req_o(device_reset_req_o), .irq_o(irq_o));
`default_nettype wire

// >>> dv/test_hw_return_stack.sv
// self-checking bench for hw_return_stack
// assumes the core model and checker compile beside it
`timescale 1ns/10ps
`default_nettype none
module test_hw_return_stack;
  import rstack_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  core_req_t core_req;
  reg_req_t reg_req = '0;
  logic [ENTRY_W-1:0] pop_pc;
  logic pop_valid;
  logic dev_rst;
  logic irq;
  logic [DATA_W-1:0] rdata;
  int err_total = 0;
  int check_count = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  rstack_core_model core (.sys_clk_i(sys_clk_i), .core_req_o(core_req), .pop_pc_i(pop_pc), .pop_valid_i(pop_valid));
  hw_return_stack dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .core_req_i(core_req), .pop_pc_o(pop_pc),
    .pop_valid_o(pop_valid), .reg_req_i(reg_req), .reg_rdata_o(rdata), .device_reset_req_o(dev_rst), .irq_o(irq));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i) reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  // data stand for one cycle only, so they are sampled mid-cycle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk_i) reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i) reg_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    @(negedge sys_clk_i) cmp(rdata, exp);
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #200000;
    err_total++;
    $display("MISMATCH %0t watchdog", $time);
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(OFS_PTR, 8'h1f);
    rd(OFS_STATUS, 8'h00);
    $display("reset done");
    core.call(15'h1234);
    rd(OFS_PTR, 8'h00);
    rd(OFS_TOP_LOW, 8'h34);
    rd(OFS_TOP_HIGH, 8'h12);
    core.ret();
    cmp(core.ret_pc, 15'h1234);
    cmp(core.ret_seen, 1'b1);
    rd(OFS_PTR, 8'h1f);
    core.call_ret(15'h2a55);
    cmp(core.ret_pc, 15'h2a55);
    cmp(core.ret_seen, 1'b1);
    rd(OFS_PTR, 8'h1f);
    $display("single call done");
    for (int i = 0; i < 17; i++)
      core.call(15'h4000 + 15'(i));
    rd(OFS_PTR, 8'h10);
    rd(OFS_TOP_LOW, 8'h10);
    rd(OFS_TOP_HIGH, 8'h40);
    rd(OFS_STATUS, 8'h01);
    cmp(irq, 1'b0);
    wr(OFS_MASK, 8'h01);
    rd(OFS_MASK, 8'h01);
    cmp(irq, 1'b1);
    wr(OFS_STATUS, 8'h01);
    rd(OFS_STATUS, 8'h00);
    cmp(irq, 1'b0);
    core.ret();
    cmp(core.ret_pc, 15'h4010);
    rd(OFS_PTR, 8'h0f);
    $display("wrap done");
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    core.ret();
    cmp(dev_rst, 1'b0);
    rd(OFS_PTR, 8'h1e);
    rd(OFS_STATUS, 8'h02);
    wr(OFS_PTR, 8'h03);
    wr(OFS_TOP_LOW, 8'h5a);
    wr(OFS_TOP_HIGH, 8'hff);
    rd(OFS_TOP_HIGH, 8'h7f);
    rd(OFS_TOP_LOW, 8'h5a);
    rd(4'h9, 8'h00);
    wr(OFS_CONFIG, 8'h01);
    rd(OFS_CONFIG, 8'h01);
    wr(OFS_PTR, 8'h1f);
    core.ret();
    cmp(dev_rst, 1'b1);
    wr(OFS_PTR, 8'h0f);
    core.call(15'h0abc);
    @(negedge sys_clk_i);
    cmp(dev_rst, 1'b1);
    rd(OFS_STATUS, 8'h03);
    $display("fault done");
    stop_test();
  end
endmodule : test_hw_return_stack
`default_nettype wire
